// file: design/maxc_pkg.sv
// package: constants and types of the motion io control block
package maxc_pkg;
  localparam int NUM_AXES_DEF   = 4;
  localparam int MIN_AXES       = 2;
  localparam int POS_W_DEF      = 32;
  localparam int NUM_PROGS      = 9;
  localparam int MAX_RUNNING    = 4;
  localparam int MAX_LINES      = 1000;
  localparam int LINE_W         = 10;
  localparam int ADDR_WINDOW    = 16;
  localparam int PARAM_COUNT    = 80;
  localparam int PARAM_AW       = 7;
  localparam int CMD_W          = 16;
  localparam int EXEC_DEPTH     = 50;
  localparam int EXEC_AW        = 6;
  localparam logic [3:0] PROG_SEL_RST = 4'h1;
  localparam logic       START_POL_RST = 1'b1;
  localparam logic       STOP_POL_RST  = 1'b1;
  // command mode classes
  localparam logic [1:0] CLS_IMM  = 2'h1;
  localparam logic [1:0] CLS_PROG = 2'h2;
  localparam logic [1:0] CLS_BOTH = 2'h3;
  // command word field positions
  localparam int CMD_CLS_LSB    = 14;
  localparam int CMD_SLOT_LSB   = 10;

  typedef enum logic [3:0] {
    ST_LOAD  = 4'b0001,
    ST_RUN   = 4'b0010,
    ST_KILL  = 4'b0100,
    ST_FAULT = 4'b1000
  } maxc_state_type;
endpackage

// file: design/maxc_axis.sv
// one axis: limits, trigger compare and position capture
module maxc_axis
  import maxc_pkg::*;
#(
  parameter int POS_W = POS_W_DEF
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic             i_lim_pos_n,
  input  wire logic             i_lim_neg_n,
  input  wire logic             i_ref_n,
  input  wire logic             i_capture,
  input  wire logic             i_cap_en,
  input  wire logic             i_trig_en,
  input  wire logic             i_trig_pol,
  input  wire logic [POS_W-1:0] i_position,
  input  wire logic [POS_W-1:0] i_compare,
  output logic                  o_lim_pos,
  output logic                  o_lim_neg,
  output logic                  o_home,
  output logic                  o_trig,
  output logic [POS_W-1:0]      o_cap_pos,
  output logic                  o_cap_hit
);
  typedef struct packed {
    logic [2:0]       s_pos;
    logic [2:0]       s_neg;
    logic [2:0]       s_ref;
    logic [2:0]       s_cap;
    logic             trig;
    logic             cap_hit;
    logic [POS_W-1:0] cap_pos;
  } maxc_ax_type;
  maxc_ax_type ax_q, ax_d;

  always_comb begin
    ax_d = ax_q;
    ax_d.s_pos = {ax_q.s_pos[1:0], i_lim_pos_n};
    ax_d.s_neg = {ax_q.s_neg[1:0], i_lim_neg_n};
    ax_d.s_ref = {ax_q.s_ref[1:0], i_ref_n};
    ax_d.s_cap = {ax_q.s_cap[1:0], i_capture};
    ax_d.cap_hit = 1'b0;
    // compare hit turns the trigger to its active level
    if (!i_trig_en) begin
      ax_d.trig = 1'b0;
    end else if (i_position == i_compare) begin
      ax_d.trig = 1'b1; // see (R7)
    end
    // rising edge of capture latches the position
    if (i_cap_en && ax_q.s_cap[1] && !ax_q.s_cap[2]) begin
      ax_d.cap_pos = i_position; // see (R8)
      ax_d.cap_hit = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ax_q <= '0;
    end else if (i_ce) begin
      ax_q <= ax_d;
    end
  end

  assign o_lim_pos = !ax_q.s_pos[1]; // see (R1)
  assign o_lim_neg = !ax_q.s_neg[1]; // see (R20)
  assign o_home    = !ax_q.s_ref[1]; // see (R2)
  assign o_trig    = ax_q.trig ^ ~i_trig_pol;
  assign o_cap_pos = ax_q.cap_pos;
  assign o_cap_hit = ax_q.cap_hit;

  property p_cap_latch;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && i_cap_en && ax_q.s_cap[1] && !ax_q.s_cap[2])
      |=> (o_cap_pos == $past(i_position)) && o_cap_hit;
  endproperty
  a_cap_latch: assert property (p_cap_latch) // see (R8)
    else $error("capture did not latch position");

  property p_trig_hit;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && i_trig_en && i_position == i_compare) |=> ax_q.trig;
  endproperty
  a_trig_hit: assert property (p_trig_hit) // see (R7)
    else $error("trigger missed compare");

  property p_lim_sync;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && !i_lim_pos_n) ##1 i_ce |=> o_lim_pos;
  endproperty
  a_lim_sync: assert property (p_lim_sync) // see (R1)
    else $error("low positive limit not seen as active");

  c_cap: cover property (@(posedge i_clk) o_cap_hit);
endmodule

// file: design/maxc_top.sv
// top: motion io control, program slots and command dispatch
//
// Behaviour
// (R1) positive limit input is active low
// (R2) reference switch, low active, marks home
// (R3) ready high only when ready, no fault
// (R4) ready low while ok indicator flashes/off
// (R5) start input runs selected program, polarity set
// (R6) stop halts selected program at next wait
// (R7) trigger edge when position meets compare value
// (R8) capture input latches actual axis position
// (R9) two to four axes, interpolation among them
// (R10) sixteen host addresses used
// (R11) interpolation only among own axes
// (R12) nine slots, at most four running
// (R13) at most 1000 lines per program
// (R14) parameters copied from nonvolatile at power-up
// (R15) host saves explicitly, never cyclically
// (R16) immediate commands queued, run in order
// (R17) program commands stored into slot 1-9
// (R18) commands accepted only in permitted mode
// (R19) amplifier ok low kills all motion
// (R20) negative limit input, active low
// (R21) limit blocks motion toward it, drops ready
module maxc_top
  import maxc_pkg::*;
#(
  parameter int NUM_AXES = NUM_AXES_DEF,
  parameter int POS_W    = POS_W_DEF
) (
  input  wire logic                      I_CLOCK,
  input  wire logic                      I_RST,
  input  wire logic                      I_CE,
  input  wire logic [NUM_AXES-1:0]       I_POSITIVE_LIMIT_INPUT_N,
  input  wire logic [NUM_AXES-1:0]       I_NEGATIVE_LIMIT_INPUT_N,
  input  wire logic [NUM_AXES-1:0]       I_REF_SWITCH_N,
  input  wire logic [NUM_AXES-1:0]       I_CAPTURE,
  input  wire logic [NUM_AXES-1:0]       I_AMP_OK,
  input  wire logic                      I_START,
  input  wire logic                      I_STOP,
  input  wire logic [NUM_AXES*POS_W-1:0] I_POSITION,
  input  wire logic [NUM_AXES*POS_W-1:0] I_COMPARE,
  input  wire logic [NUM_AXES-1:0]       I_TRIG_EN,
  input  wire logic [NUM_AXES-1:0]       I_TRIG_POL,
  input  wire logic [NUM_AXES-1:0]       I_CAP_EN,
  input  wire logic [NUM_AXES-1:0]       I_MOVE_DIR_POS,
  input  wire logic [NUM_AXES-1:0]       I_MOVE_REQ,
  input  wire logic                      I_SYS_READY,
  input  wire logic                      I_OK_LED_STEADY,
  input  wire logic                      I_NV_VALID,
  input  wire logic [CMD_W-1:0]          I_NV_DATA,
  input  wire logic [3:0]                I_HOST_ADDR,
  input  wire logic                      I_HOST_WR,
  input  wire logic [CMD_W-1:0]          I_HOST_DATA,
  input  wire logic                      I_EXEC_DONE,
  input  wire logic                      I_WAIT_REACHED,
  input  wire logic [3:0]                I_PROG_FINISHED,
  output logic                           O_MODULE_READY_OUTPUT,
  output logic [NUM_AXES-1:0]            O_TRIGGER,
  output logic [NUM_AXES*POS_W-1:0]      O_CAPTURE_POS,
  output logic [NUM_AXES-1:0]            O_CAPTURE_HIT,
  output logic [NUM_AXES-1:0]            O_HOME,
  output logic [NUM_AXES-1:0]            O_MOVE_ALLOW,
  output logic                           O_KILL,
  output logic                           O_PARAM_LOADED,
  output logic [3:0]                     O_RUN_COUNT,
  output logic [NUM_PROGS-1:0]           O_PROG_RUNNING,
  output logic                           O_EXEC_VALID,
  output logic [CMD_W-1:0]               O_EXEC_CMD,
  output logic                           O_CMD_REJECT
);
  // host window addresses
  localparam logic [3:0] A_IMM      = 4'h0;
  localparam logic [3:0] A_PROG     = 4'h1;
  localparam logic [3:0] A_PROG_SEL = 4'h2;
  localparam logic [3:0] A_POL      = 4'h3;

  typedef struct packed {
    maxc_state_type            st;
    logic [1:0]                s_start;
    logic [1:0]                s_stop;
    logic                      start_prev;
    logic [NUM_AXES-1:0]       s_aok1;
    logic [NUM_AXES-1:0]       s_aok2;
    logic [PARAM_AW-1:0]       ld_cnt;
    logic [3:0]                prog_sel;
    logic                      start_pol;
    logic                      stop_pol;
    logic                      stop_pend;
    logic [NUM_PROGS-1:0]      running;
    logic [EXEC_AW-1:0]        wr_ptr;
    logic [EXEC_AW-1:0]        rd_ptr;
    logic [EXEC_AW:0]          level;
    logic                      exec_valid;
    logic [CMD_W-1:0]          exec_cmd;
    logic                      reject;
    logic                      ready;
    logic [NUM_AXES-1:0]       allow;
  } maxc_top_type;
  maxc_top_type r_q, r_d;

  logic [CMD_W-1:0] param_mem  [PARAM_COUNT];
  logic [CMD_W-1:0] exec_mem   [EXEC_DEPTH];
  logic [LINE_W-1:0] line_cnt  [NUM_PROGS];
  logic [NUM_AXES-1:0] lim_pos, lim_neg;
  logic [1:0]          cls;
  logic [3:0]          slot;
  logic                imm_ok, prog_ok, push, pop;
  logic                start_lvl, stop_lvl;
  logic [3:0]          nrun;

  // ------------------------------------------------------------
  // axes
  // ------------------------------------------------------------
  for (genvar g = 0; g < NUM_AXES; g++) begin : g_ax // see (R9)
    maxc_axis #(.POS_W(POS_W)) u_axis (
      .i_clk       (I_CLOCK),
      .i_rst       (I_RST),
      .i_ce        (I_CE),
      .i_lim_pos_n (I_POSITIVE_LIMIT_INPUT_N[g]),
      .i_lim_neg_n (I_NEGATIVE_LIMIT_INPUT_N[g]),
      .i_ref_n     (I_REF_SWITCH_N[g]),
      .i_capture   (I_CAPTURE[g]),
      .i_cap_en    (I_CAP_EN[g]),
      .i_trig_en   (I_TRIG_EN[g]),
      .i_trig_pol  (I_TRIG_POL[g]),
      .i_position  (I_POSITION[g*POS_W +: POS_W]),
      .i_compare   (I_COMPARE[g*POS_W +: POS_W]),
      .o_lim_pos   (lim_pos[g]),
      .o_lim_neg   (lim_neg[g]),
      .o_home      (O_HOME[g]),
      .o_trig      (O_TRIGGER[g]),
      .o_cap_pos   (O_CAPTURE_POS[g*POS_W +: POS_W]),
      .o_cap_hit   (O_CAPTURE_HIT[g])
    );
  end

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  assign cls  = I_HOST_DATA[CMD_CLS_LSB +: 2];
  assign slot = I_HOST_DATA[CMD_SLOT_LSB +: 4];
  assign imm_ok  = (cls == CLS_IMM) || (cls == CLS_BOTH); // see (R18)
  assign prog_ok = ((cls == CLS_PROG) || (cls == CLS_BOTH)) // see (R18)
                   && slot >= 4'h1 && slot <= 4'(NUM_PROGS); // see (R17)
  assign push = I_HOST_WR && I_HOST_ADDR == A_IMM && imm_ok
                && r_q.st == ST_RUN && r_q.level < (EXEC_AW+1)'(EXEC_DEPTH);
  assign pop  = r_q.exec_valid && I_EXEC_DONE;
  assign start_lvl = r_q.s_start[1] ~^ r_q.start_pol; // see (R5)
  assign stop_lvl  = r_q.s_stop[1] ~^ r_q.stop_pol;   // see (R6)

  always_comb begin
    nrun = '0;
    for (int i = 0; i < NUM_PROGS; i++) begin
      nrun = nrun + 4'(r_q.running[i]);
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.s_start = {r_q.s_start[0], I_START};
    r_d.s_stop  = {r_q.s_stop[0], I_STOP};
    r_d.start_prev = start_lvl;
    r_d.s_aok1 = I_AMP_OK;
    r_d.s_aok2 = r_q.s_aok1;
    r_d.reject = 1'b0;
    r_d.running = r_q.running & ~NUM_PROGS'(I_PROG_FINISHED != 4'h0
                  ? (9'h1 << (I_PROG_FINISHED - 4'h1)) : 9'h0);
    case (r_q.st)
      ST_LOAD: begin
        if (I_NV_VALID) begin
          r_d.ld_cnt = r_q.ld_cnt + 7'h1; // see (R14)
          if (r_q.ld_cnt == 7'(PARAM_COUNT - 1)) begin
            r_d.st = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (!(&r_q.s_aok2)) begin
          r_d.st = ST_KILL; // see (R19)
        end
      end
      ST_KILL: begin
        r_d.running = '0;
        r_d.stop_pend = 1'b0;
        if (&r_q.s_aok2) begin
          r_d.st = ST_RUN;
        end
      end
      default: begin
        r_d.st = ST_LOAD;
      end
    endcase
    // host window: four of the sixteen addresses decoded, others ignored
    if (I_HOST_WR && r_q.st == ST_RUN) begin // see (R10)
      if (I_HOST_ADDR == A_IMM) begin
        r_d.reject = !push; // see (R16)
      end else if (I_HOST_ADDR == A_PROG) begin
        r_d.reject = !prog_ok
          || line_cnt[slot - 4'h1] == LINE_W'(MAX_LINES); // see (R13)
      end else if (I_HOST_ADDR == A_PROG_SEL) begin
        r_d.prog_sel = I_HOST_DATA[3:0];
      end else if (I_HOST_ADDR == A_POL) begin
        r_d.start_pol = I_HOST_DATA[0];
        r_d.stop_pol  = I_HOST_DATA[1];
      end
    end
    // start: edge to active level launches the selected program
    if (r_q.st == ST_RUN && start_lvl && !r_q.start_prev
        && r_q.prog_sel >= 4'h1 && r_q.prog_sel <= 4'(NUM_PROGS)
        && nrun < 4'(MAX_RUNNING)) begin // see (R12)
      r_d.running[r_q.prog_sel - 4'h1] = 1'b1; // see (R5)
    end
    // stop: held pending until the program reaches a wait
    if (r_q.stop_pend && I_WAIT_REACHED) begin
      r_d.running[r_q.prog_sel - 4'h1] = 1'b0; // see (R6)
      r_d.stop_pend = 1'b0;
    end
    if (stop_lvl) begin
      r_d.stop_pend = 1'b1;
    end
    // execution queue in arrival order
    if (push) begin
      r_d.wr_ptr = (r_q.wr_ptr == EXEC_AW'(EXEC_DEPTH - 1))
                   ? '0 : r_q.wr_ptr + 6'h1;
    end
    if ((pop || !r_q.exec_valid) && r_q.level != '0) begin
      r_d.rd_ptr = (r_q.rd_ptr == EXEC_AW'(EXEC_DEPTH - 1))
                   ? '0 : r_q.rd_ptr + 6'h1;
      r_d.exec_valid = 1'b1;
      r_d.exec_cmd = exec_mem[r_q.rd_ptr]; // see (R16)
    end else if (pop) begin
      r_d.exec_valid = 1'b0;
    end
    r_d.level = r_q.level + (EXEC_AW+1)'(push)
      - (EXEC_AW+1)'((pop || !r_q.exec_valid) && r_q.level != '0);
    if (r_q.st == ST_KILL) begin
      r_d.exec_valid = 1'b0;
      r_d.level = '0;
      r_d.rd_ptr = r_q.wr_ptr;
    end
    // motion only away from an active limit
    for (int i = 0; i < NUM_AXES; i++) begin
      r_d.allow[i] = I_MOVE_REQ[i] && r_q.st == ST_RUN // see (R11)
        && !(I_MOVE_DIR_POS[i] ? lim_pos[i] : lim_neg[i]); // see (R21)
    end
    r_d.ready = I_SYS_READY && I_OK_LED_STEADY // see (R4)
      && r_q.st == ST_RUN && !(|lim_pos) && !(|lim_neg); // see (R3)
  end

  // ------------------------------------------------------------
  // registers and memories
  // ------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      r_q <= '0;
      r_q.st <= ST_LOAD;
      r_q.prog_sel <= PROG_SEL_RST;
      r_q.start_pol <= START_POL_RST;
      r_q.stop_pol <= STOP_POL_RST;
      for (int i = 0; i < NUM_PROGS; i++) begin
        line_cnt[i] <= '0;
      end
    end else if (I_CE) begin
      r_q <= r_d;
      if (r_q.st == ST_RUN && I_HOST_WR && I_HOST_ADDR == A_PROG
          && prog_ok && line_cnt[slot - 4'h1] != LINE_W'(MAX_LINES)) begin
        line_cnt[slot - 4'h1] <= line_cnt[slot - 4'h1] + 10'h1; // see (R17)
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_CE && r_q.st == ST_LOAD && I_NV_VALID) begin
      param_mem[r_q.ld_cnt] <= I_NV_DATA; // see (R14)
    end
    if (I_CE && push) begin
      exec_mem[r_q.wr_ptr] <= I_HOST_DATA;
    end
  end

  assign O_MODULE_READY_OUTPUT = r_q.ready;
  assign O_MOVE_ALLOW   = r_q.allow;
  assign O_KILL         = (r_q.st == ST_KILL);
  assign O_PARAM_LOADED = (r_q.st != ST_LOAD);
  assign O_RUN_COUNT    = nrun;
  assign O_PROG_RUNNING = r_q.running;
  assign O_EXEC_VALID   = r_q.exec_valid;
  assign O_EXEC_CMD     = r_q.exec_cmd;
  assign O_CMD_REJECT   = r_q.reject;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_ready_led;
    @(posedge I_CLOCK) disable iff (I_RST)
      (I_CE && !I_OK_LED_STEADY) |=> !O_MODULE_READY_OUTPUT;
  endproperty
  a_ready_led: assert property (p_ready_led) // see (R4)
    else $error("ready high while ok indicator not steady");

  property p_ready_lim;
    @(posedge I_CLOCK) disable iff (I_RST)
      (I_CE && (|lim_pos || |lim_neg)) |=> !O_MODULE_READY_OUTPUT;
  endproperty
  a_ready_lim: assert property (p_ready_lim) // see (R3)
    else $error("ready high with a limit active");

  property p_kill;
    @(posedge I_CLOCK) disable iff (I_RST)
      (I_CE && r_q.st == ST_RUN && !(&r_q.s_aok2)) |=> O_KILL;
  endproperty
  a_kill: assert property (p_kill) // see (R19)
    else $error("amplifier fault did not kill");

  property p_maxrun;
    @(posedge I_CLOCK) disable iff (I_RST)
      O_RUN_COUNT <= 4'(MAX_RUNNING);
  endproperty
  a_maxrun: assert property (p_maxrun) // see (R12)
    else $error("too many programs running");

  property p_dir_block;
    @(posedge I_CLOCK) disable iff (I_RST)
      (I_CE && I_MOVE_DIR_POS[0] && lim_pos[0]) |=> !O_MOVE_ALLOW[0];
  endproperty
  a_dir_block: assert property (p_dir_block) // see (R21)
    else $error("motion allowed into positive limit");

  property p_bad_cls;
    @(posedge I_CLOCK) disable iff (I_RST)
      (I_CE && r_q.st == ST_RUN && I_HOST_WR && I_HOST_ADDR == A_IMM
       && cls == CLS_PROG) |=> O_CMD_REJECT;
  endproperty
  a_bad_cls: assert property (p_bad_cls) // see (R18)
    else $error("program-only command accepted as immediate");

  c_ready:  cover property (@(posedge I_CLOCK) O_MODULE_READY_OUTPUT);
  c_kill:   cover property (@(posedge I_CLOCK) O_KILL);
  c_exec:   cover property (@(posedge I_CLOCK) O_EXEC_VALID);
endmodule

// file: tb/maxc_host_model.sv
// host side model: parameter store stream and command executor
module maxc_host_model
  import maxc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_exec_valid,
  input  wire logic        i_slow,
  output logic             o_nv_valid,
  output logic [CMD_W-1:0] o_nv_data,
  output logic             o_exec_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int   nv_cnt;
  int   run_cnt;
  logic loading;
  assign loading = nv_cnt < PARAM_COUNT;
  // ---------------------------------------
  // parameter stream and command completion
  // ---------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      nv_cnt      <= 0;
      run_cnt     <= 0;
      o_nv_valid  <= 1'b0;
      o_nv_data   <= 16'h0000;
      o_exec_done <= 1'b0;
    end else begin
      // one stored word per cycle until the block is full
      o_nv_valid  <= loading;
      // a released data bus toggles instead of holding its value
      o_nv_data   <= loading ? CMD_W'(nv_cnt + 1) : ~o_nv_data;
      nv_cnt      <= loading ? nv_cnt + 1 : nv_cnt;
      // each command finishes after a short or a long run
      o_exec_done <= 1'b0;
      run_cnt     <= 0;
      if (i_exec_valid && !o_exec_done && run_cnt < (i_slow ? 6 : 1)) begin
        run_cnt <= run_cnt + 1;
      end else if (i_exec_valid && !o_exec_done) begin
        o_exec_done <= 1'b1;
      end
      // no save command is ever issued from here
    end
  end
endmodule

// file: tb/tb_maxc_top.sv
// self-checking bench of the motion io control block
module tb_maxc_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------
  // signals and instances
  // ---------------------------
  localparam int NA = 2;
  localparam int PW = 32;
  logic             I_CLOCK = 1'b0, I_RST = 1'b1, I_CE = 1'b1;
  logic             I_START = 1'b0, I_STOP = 1'b0, I_HOST_WR = 1'b0;
  logic             I_SYS_READY = 1'b1, I_OK_LED_STEADY = 1'b1;
  logic             I_WAIT_REACHED = 1'b0, slow = 1'b0, rej_seen = 1'b0;
  logic [NA-1:0]    I_POSITIVE_LIMIT_INPUT_N = '1;
  logic [NA-1:0]    I_NEGATIVE_LIMIT_INPUT_N = '1;
  logic [NA-1:0]    I_REF_SWITCH_N = '1, I_AMP_OK = '1, I_CAPTURE = '0;
  logic [NA-1:0]    I_TRIG_EN = '0, I_TRIG_POL = '0, I_CAP_EN = '0;
  logic [NA-1:0]    I_MOVE_DIR_POS = '0, I_MOVE_REQ = '0, hit_seen = '0;
  logic [NA*PW-1:0] I_POSITION = '0, I_COMPARE = '1, O_CAPTURE_POS;
  logic [3:0]       I_HOST_ADDR = '0, I_PROG_FINISHED = '0, O_RUN_COUNT;
  logic [15:0]      I_HOST_DATA = '0, I_NV_DATA, O_EXEC_CMD;
  logic             I_NV_VALID, I_EXEC_DONE, O_MODULE_READY_OUTPUT, O_KILL;
  logic             O_PARAM_LOADED, O_EXEC_VALID, O_CMD_REJECT;
  logic [NA-1:0]    O_TRIGGER, O_CAPTURE_HIT, O_HOME, O_MOVE_ALLOW;
  logic [8:0]       O_PROG_RUNNING;
  logic [15:0]      done_q[$];
  int               miscompares = 0, n_tests = 0;

  maxc_top #(.NUM_AXES(NA), .POS_W(PW)) maxc_top_inst (
    .I_CLOCK, .I_RST, .I_CE, .I_POSITIVE_LIMIT_INPUT_N,
    .I_NEGATIVE_LIMIT_INPUT_N, .I_REF_SWITCH_N, .I_CAPTURE, .I_AMP_OK,
    .I_START, .I_STOP, .I_POSITION, .I_COMPARE, .I_TRIG_EN, .I_TRIG_POL,
    .I_CAP_EN, .I_MOVE_DIR_POS, .I_MOVE_REQ, .I_SYS_READY,
    .I_OK_LED_STEADY, .I_NV_VALID, .I_NV_DATA, .I_HOST_ADDR, .I_HOST_WR,
    .I_HOST_DATA, .I_EXEC_DONE, .I_WAIT_REACHED, .I_PROG_FINISHED,
    .O_MODULE_READY_OUTPUT, .O_TRIGGER, .O_CAPTURE_POS, .O_CAPTURE_HIT,
    .O_HOME, .O_MOVE_ALLOW, .O_KILL, .O_PARAM_LOADED, .O_RUN_COUNT,
    .O_PROG_RUNNING, .O_EXEC_VALID, .O_EXEC_CMD, .O_CMD_REJECT);
  maxc_host_model maxc_host_model_inst (
    .i_clk(I_CLOCK), .i_rst(I_RST), .i_exec_valid(O_EXEC_VALID),
    .i_slow(slow), .o_nv_valid(I_NV_VALID), .o_nv_data(I_NV_DATA),
    .o_exec_done(I_EXEC_DONE));

  initial forever #5 I_CLOCK = ~I_CLOCK;

  always @(posedge I_CLOCK) begin
    if (O_CMD_REJECT === 1'b1) rej_seen <= 1'b1;
    if (!I_RST) hit_seen <= hit_seen | O_CAPTURE_HIT;
    if (O_EXEC_VALID === 1'b1 && I_EXEC_DONE === 1'b1)
      done_q.push_back(O_EXEC_CMD);
  end
  // ---------------------------
  // helpers and scenarios
  // ---------------------------
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge I_CLOCK);
    #1;
  endtask
  task automatic host_wr(logic [3:0] a, logic [15:0] d);
    @(posedge I_CLOCK);
    I_HOST_ADDR <= a;
    I_HOST_DATA <= d;
    I_HOST_WR <= 1'b1;
    @(posedge I_CLOCK);
    I_HOST_WR <= 1'b0;
  endtask
  task automatic wr_rej(logic [3:0] a, logic [15:0] d, logic e);
    @(posedge I_CLOCK);
    rej_seen <= 1'b0;
    host_wr(a, d);
    wt(3);
    chk("reject", e, rej_seen);
  endtask
  task automatic start_prog(logic [3:0] s);
    host_wr(4'h2, {12'h000, s});
    repeat (2) begin
      @(posedge I_CLOCK);
      I_START <= ~I_START;
      wt(4);
    end
  endtask
  task automatic t_load();
    host_wr(4'h0, 16'h4077);
    wt(1);
    chk("loaded", 1'b0, O_PARAM_LOADED);
    for (int i = 0; i < 200 && O_PARAM_LOADED !== 1'b1; i++) wt(1);
    chk("loaded", 1'b1, O_PARAM_LOADED);
    wt(6);
    chk("load write", 0, done_q.size());
    chk("ready", 1'b1, O_MODULE_READY_OUTPUT);
  endtask
  task automatic t_limits();
    @(posedge I_CLOCK);
    I_MOVE_REQ <= 2'b11;
    I_MOVE_DIR_POS <= 2'b11;
    I_POSITIVE_LIMIT_INPUT_N <= 2'b10;
    wt(5);
    chk("ready", 1'b0, O_MODULE_READY_OUTPUT);
    chk("allow", 2'b10, O_MOVE_ALLOW);
    @(posedge I_CLOCK);
    I_MOVE_DIR_POS <= 2'b00;
    wt(5);
    chk("allow", 2'b11, O_MOVE_ALLOW);
    @(posedge I_CLOCK);
    I_POSITIVE_LIMIT_INPUT_N <= 2'b11;
    I_NEGATIVE_LIMIT_INPUT_N <= 2'b01;
    wt(5);
    chk("allow", 2'b01, O_MOVE_ALLOW);
    @(posedge I_CLOCK);
    I_NEGATIVE_LIMIT_INPUT_N <= 2'b11;
    I_OK_LED_STEADY <= 1'b0;
    wt(5);
    chk("ready", 1'b0, O_MODULE_READY_OUTPUT);
    @(posedge I_CLOCK);
    I_OK_LED_STEADY <= 1'b1;
    I_SYS_READY <= 1'b0;
    I_REF_SWITCH_N <= 2'b01;
    wt(5);
    chk("ready", 1'b0, O_MODULE_READY_OUTPUT);
    chk("home", 2'b10, O_HOME);
    @(posedge I_CLOCK);
    I_SYS_READY <= 1'b1;
    I_REF_SWITCH_N <= 2'b11;
  endtask
  task automatic t_cap_trig();
    @(posedge I_CLOCK);
    I_POSITION <= {32'h0000_2222, 32'h0000_1111};
    I_CAP_EN <= 2'b01;
    I_CAPTURE <= 2'b11;
    wt(5);
    chk("cap pos", {32'h0, 32'h0000_1111}, O_CAPTURE_POS);
    chk("cap hit", 2'b01, hit_seen);
    @(posedge I_CLOCK);
    I_POSITION <= {32'h0000_3333, 32'h0000_4444};
    I_TRIG_POL <= 2'b01;
    I_TRIG_EN <= 2'b11;
    I_COMPARE <= {32'h0000_5555, 32'h0000_5555};
    wt(4);
    chk("cap hold", {32'h0, 32'h0000_1111}, O_CAPTURE_POS);
    chk("trig idle", 2'b10, O_TRIGGER);
    @(posedge I_CLOCK);
    I_POSITION <= {32'h0000_5555, 32'h0000_5555};
    wt(4);
    chk("trig", 2'b01, O_TRIGGER);
    @(posedge I_CLOCK);
    I_TRIG_EN <= 2'b00;
  endtask
  task automatic t_exec();
    logic [15:0] ex [3] = '{16'h4011, 16'hc022, 16'h4033};
    done_q.delete();
    host_wr(4'h1, 16'h8c05);
    host_wr(4'h0, ex[0]);
    host_wr(4'h0, ex[1]);
    slow <= 1'b1;
    host_wr(4'h0, ex[2]);
    host_wr(4'h5, 16'h4044);
    for (int i = 0; i < 200 && done_q.size() < 3; i++) wt(1);
    wt(20);
    chk("exec count", 3, done_q.size());
    for (int i = 0; i < 3; i++) chk("exec cmd", ex[i], done_q[i]);
    slow <= 1'b0;
    host_wr(4'h0, 16'h4066);
    wt(8);
    chk("exec after drain", 16'h4066, done_q[3]);
    wr_rej(4'h0, 16'h8001, 1'b1);
    wr_rej(4'h1, 16'h4001, 1'b1);
    wr_rej(4'h1, 16'h8000, 1'b1);
    wr_rej(4'h1, 16'ha801, 1'b1);
    wr_rej(4'h1, 16'hc401, 1'b0);
    chk("exec count", 4, done_q.size());
  endtask
  task automatic t_lines();
    @(posedge I_CLOCK);
    rej_seen <= 1'b0;
    for (int i = 0; i < 1000; i++) host_wr(4'h1, 16'h9000 | 16'(i));
    wt(3);
    chk("line 1000", 1'b0, rej_seen);
    wr_rej(4'h1, 16'h9000, 1'b1);
  endtask
  task automatic t_progs();
    for (int s = 1; s <= 5; s++) start_prog(4'(s));
    chk("running", 9'h00f, O_PROG_RUNNING);
    chk("run count", 4'h4, O_RUN_COUNT);
    @(posedge I_CLOCK);
    I_PROG_FINISHED <= 4'h2;
    @(posedge I_CLOCK);
    I_PROG_FINISHED <= 4'h0;
    host_wr(4'h2, 16'h0001);
    @(posedge I_CLOCK);
    I_STOP <= 1'b1;
    wt(6);
    chk("stop pending", 9'h00d, O_PROG_RUNNING);
    @(posedge I_CLOCK);
    I_WAIT_REACHED <= 1'b1;
    @(posedge I_CLOCK);
    I_WAIT_REACHED <= 1'b0;
    I_STOP <= 1'b0;
    wt(3);
    chk("stopped", 9'h00c, O_PROG_RUNNING);
    host_wr(4'h2, 16'h0003);
    @(posedge I_CLOCK);
    I_START <= 1'b1;
    wt(5);
    host_wr(4'h3, 16'h0002);
    start_prog(4'h9);
    chk("low start", 9'h10c, O_PROG_RUNNING);
    chk("run count", 4'h3, O_RUN_COUNT);
    @(posedge I_CLOCK);
    I_CE <= 1'b0;
    I_PROG_FINISHED <= 4'h9;
    wt(3);
    chk("frozen", 9'h10c, O_PROG_RUNNING);
    @(posedge I_CLOCK);
    I_CE <= 1'b1;
    I_PROG_FINISHED <= 4'h0;
  endtask
  task automatic t_kill();
    @(posedge I_CLOCK);
    I_AMP_OK <= 2'b01;
    wt(5);
    chk("kill", 1'b1, O_KILL);
    chk("running", 9'h000, O_PROG_RUNNING);
    host_wr(4'h0, 16'h4055);
    @(posedge I_CLOCK);
    I_AMP_OK <= 2'b11;
    wt(8);
    chk("kill", 1'b0, O_KILL);
    chk("exec", 1'b0, O_EXEC_VALID);
    chk("ready", 1'b1, O_MODULE_READY_OUTPUT);
    start_prog(4'h2);
    chk("low start", 9'h002, O_PROG_RUNNING);
    host_wr(4'h3, 16'h0000);
    @(posedge I_CLOCK);
    I_WAIT_REACHED <= 1'b1;
    @(posedge I_CLOCK);
    I_WAIT_REACHED <= 1'b0;
    wt(3);
    chk("low stop", 9'h000, O_PROG_RUNNING);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ---------------------------
  // run
  // ---------------------------
  initial begin
    repeat (2) @(posedge I_CLOCK);
    I_RST <= 1'b0;
    t_load();
    t_limits();
    t_cap_trig();
    t_exec();
    t_lines();
    t_progs();
    t_kill();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge I_CLOCK);
    miscompares++;
    complete_run();
  end
endmodule
